//--- core/analog_input_scan_sequencer.sv
// Analog input scan sequencer with AXI4-Lite control.
`timescale 1ns/100ps

// How it works
// - Revolution counter steps once per revolution end
// - First revolution all zeros, last all ones
// - Four settle bits give fourteen settling revolutions
// - Optional three or two bits settle six/two
// - Guard cleared from last-rev end to mid-sector
// - No relay closes while guard cleared
// - Sector MSB sets guard; held until last-rev end
// - One relay per group forms selected set
// - Relay select counter five bits, no option
// - Select counter advances when guard sets
// - Close set on count and guard coincidence
// - Select counter runs full count except under test lock
// - Test lock holds scan on single input
// - Converter register bits from add-line comparison
// - Enable off forces all weight switches off
// - Enable and force make all switches conduct
// - Enable without force follows register bits
module analog_input_scan_sequencer #(
  parameter int SETTLE_W = scan_seq_pkg::SETTLE_W_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Drum timing
  input wire logic [scan_seq_pkg::DIGIT_W-1:0] digitCount,
  input wire logic [scan_seq_pkg::SECTOR_W-1:0] sectorCount,
  input wire logic timingTrackBit,
  // Converter
  input wire logic addLineDetector,
  input wire logic convLoad,
  input wire logic [3:0] convBitIndex,
  // Relay and weight outputs
  output logic [31:0] relayGate,
  output logic relayReleaseGuard,
  output logic [scan_seq_pkg::SELECT_W-1:0] relaySelectCount,
  output logic [scan_seq_pkg::CONV_W-1:0] weightSwitch,
  output logic firstRevolution,
  output logic lastRevolution,
  // AXI4-Lite write address
  input wire logic [scan_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [scan_seq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [scan_seq_pkg::DIGIT_W-1:0] digitMeta_q, digit_q;
  logic [scan_seq_pkg::SECTOR_W-1:0] sectorMeta_q, sector_q;
  logic trackMeta_q, track_q, addMeta_q, add_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      digitMeta_q <= '0;
      digit_q <= '0;
      sectorMeta_q <= '0;
      sector_q <= '0;
      trackMeta_q <= 1'b0;
      track_q <= 1'b0;
      addMeta_q <= 1'b0;
      add_q <= 1'b0;
    end else begin
      digitMeta_q <= digitCount;
      digit_q <= digitMeta_q;
      sectorMeta_q <= sectorCount;
      sector_q <= sectorMeta_q;
      trackMeta_q <= timingTrackBit;
      track_q <= trackMeta_q;
      addMeta_q <= addLineDetector;
      add_q <= addMeta_q;
    end
  end

  // ****************************************
  // Drum instants
  // ****************************************
  logic revEnd, slotPrev_q, revEndSeen_q, revEndPulse;
  logic guardSetPulse, msbPrev_q;

  // Digit and sector hold for a whole clock train, so act on the first cycle only.
  assign revEnd = (digit_q == scan_seq_pkg::LAST_DIGIT_SLOT) && (sector_q == scan_seq_pkg::FINAL_SECTOR);

  always_ff @(posedge clk) begin
    if (rst) begin
      slotPrev_q <= 1'b0;
      msbPrev_q <= 1'b0;
    end else begin
      slotPrev_q <= revEnd;
      msbPrev_q <= sector_q[scan_seq_pkg::SECTOR_W-1];
    end
  end

  assign revEndSeen_q = revEnd && !slotPrev_q;
  assign revEndPulse = revEndSeen_q && !track_q;
  assign guardSetPulse = sector_q[scan_seq_pkg::SECTOR_W-1] && !msbPrev_q
                         && digit_q == scan_seq_pkg::FIRST_DIGIT_SLOT;

  // ****************************************
  // Revolution counter
  // ****************************************
  logic firstRev, lastRev;

  settle_counter #(
    .WIDTH(SETTLE_W)
  ) u_settle (
    .clk(clk),
    .rst(rst),
    .revEnd(revEndPulse),
    .firstRev(firstRev),
    .lastRev(lastRev),
    .count()
  );

  // ****************************************
  // Relay-release guard and selection
  // ****************************************
  logic guard_q;
  logic [scan_seq_pkg::SELECT_W-1:0] select_q;
  logic [31:0] ctrl_q;
  logic [scan_seq_pkg::SELECT_W-1:0] lockSel_q;
  logic testLock;

  assign testLock = ctrl_q[scan_seq_pkg::CTRL_TESTLOCK_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      guard_q <= 1'b0;
    end else if (revEndSeen_q && lastRev) begin
      guard_q <= 1'b0;
    end else if (guardSetPulse && firstRev) begin
      guard_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      select_q <= '0;
    end else if (testLock) begin
      select_q <= lockSel_q;
    end else if (guardSetPulse && firstRev && !guard_q) begin
      select_q <= select_q + 1'b1;
    end
  end

  function automatic logic [31:0] decodeSet(input logic [scan_seq_pkg::SELECT_W-1:0] sel, input logic en);
    decodeSet = '0;
    if (en) begin
      decodeSet[sel] = 1'b1;
    end
  endfunction

  logic [31:0] relay_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      relay_q <= '0;
    end else begin
      relay_q <= decodeSet(select_q, guard_q);
    end
  end

  // ****************************************
  // Converter register and weight gates
  // ****************************************
  logic [scan_seq_pkg::CONV_W-1:0] convValue;
  logic [scan_seq_pkg::CONV_W-1:0] weight_q;
  logic convClear;
  scan_seq_pkg::gate_mode_t gateMode;

  conv_register u_conv (
    .clk(clk),
    .rst(rst),
    .clear(convClear),
    .load(convLoad),
    .bitIndex(convBitIndex),
    .compare(add_q),
    .value(convValue)
  );

  always_comb begin
    if (!ctrl_q[scan_seq_pkg::CTRL_ENABLE_BIT]) begin
      gateMode = scan_seq_pkg::GATE_OFF;
    end else if (ctrl_q[scan_seq_pkg::CTRL_FORCE_BIT]) begin
      gateMode = scan_seq_pkg::GATE_FULL;
    end else begin
      gateMode = scan_seq_pkg::GATE_REG;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      weight_q <= '0;
    end else begin
      case (gateMode)
        scan_seq_pkg::GATE_OFF: weight_q <= '0;
        scan_seq_pkg::GATE_FULL: weight_q <= '1;
        scan_seq_pkg::GATE_REG: weight_q <= convValue;
        default: weight_q <= '0;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic [scan_seq_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awHave_q, wHave_q, bValid_q, arReady_q, rValid_q, awReady_q, wReady_q;
  logic [1:0] bResp_q, rResp_q;
  logic [31:0] rData_q;
  logic doWrite, wrHit, clrPulse_q;

  assign doWrite = awHave_q && wHave_q && !bValid_q;
  assign wrHit = (awAddr_q == scan_seq_pkg::CTRL_ADDR) || (awAddr_q == scan_seq_pkg::LOCK_ADDR);
  assign convClear = clrPulse_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      awHave_q <= 1'b0;
      awReady_q <= 1'b1;
      awAddr_q <= '0;
    end else if (s_axi_awvalid && !awHave_q) begin
      awHave_q <= 1'b1;
      awReady_q <= 1'b0;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHave_q <= 1'b0;
      awReady_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wHave_q <= 1'b0;
      wReady_q <= 1'b1;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (s_axi_wvalid && !wHave_q) begin
      wHave_q <= 1'b1;
      wReady_q <= 1'b0;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (doWrite) begin
      wHave_q <= 1'b0;
      wReady_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= scan_seq_pkg::CTRL_RESET;
      lockSel_q <= '0;
      clrPulse_q <= 1'b0;
    end else begin
      clrPulse_q <= 1'b0;
      if (doWrite && wStrb_q[0]) begin
        if (awAddr_q == scan_seq_pkg::CTRL_ADDR) begin
          ctrl_q <= {28'h0000000, 1'b0, wData_q[2:0]};
          clrPulse_q <= wData_q[scan_seq_pkg::CTRL_CONVCLR_BIT];
        end else if (awAddr_q == scan_seq_pkg::LOCK_ADDR) begin
          lockSel_q <= wData_q[scan_seq_pkg::SELECT_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bValid_q <= 1'b0;
      bResp_q <= scan_seq_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'b1;
      bResp_q <= wrHit ? scan_seq_pkg::RESP_OKAY : scan_seq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= scan_seq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arReady_q) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rResp_q <= scan_seq_pkg::RESP_OKAY;
      case (s_axi_araddr)
        scan_seq_pkg::CTRL_ADDR: rData_q <= ctrl_q;
        scan_seq_pkg::STATUS_ADDR: rData_q <= {24'h000000, firstRev, lastRev, guard_q, select_q};
        scan_seq_pkg::CONV_ADDR: rData_q <= {22'h0, convValue};
        scan_seq_pkg::LOCK_ADDR: rData_q <= {27'h0, lockSel_q};
        default: begin
          rData_q <= '0;
          rResp_q <= scan_seq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValid_q) begin
      if (s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end else begin
      arReady_q <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      firstRevolution <= 1'b0;
      lastRevolution <= 1'b0;
    end else begin
      firstRevolution <= firstRev;
      lastRevolution <= lastRev;
    end
  end

  assign relayGate = relay_q;
  assign relayReleaseGuard = guard_q;
  assign relaySelectCount = select_q;
  assign weightSwitch = weight_q;
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

endmodule

//--- core/scan_seq_pkg.sv
// Shared constants for the analog input scan sequencer.
package scan_seq_pkg;

  // ****************************************
  // Drum timing
  // ****************************************
  localparam int DIGIT_W = 5;
  localparam int SECTOR_W = 7;
  localparam logic [DIGIT_W-1:0] LAST_DIGIT_SLOT = 5'h14;
  localparam logic [DIGIT_W-1:0] FIRST_DIGIT_SLOT = 5'h01;
  localparam logic [SECTOR_W-1:0] FINAL_SECTOR = 7'h7F;
  localparam logic [SECTOR_W-1:0] MID_SECTOR = 7'h40;

  // ****************************************
  // Counters and converter
  // ****************************************
  localparam int SETTLE_W_MAX = 4;
  localparam int SETTLE_W_DEFAULT = 4;
  localparam int SELECT_W = 5;
  localparam int CONV_W = 10;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] CONV_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 8'h0C;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam int CTRL_TESTLOCK_BIT = 2;
  localparam int CTRL_CONVCLR_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {GATE_OFF, GATE_FULL, GATE_REG} gate_mode_t;

endpackage

//--- core/settle_counter.sv
// Revolution counter with a build-time width of 2, 3 or 4 flip flops.
`timescale 1ns/100ps
module settle_counter #(
  parameter int WIDTH = scan_seq_pkg::SETTLE_W_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic revEnd,
  // State
  output logic firstRev,
  output logic lastRev,
  output logic [scan_seq_pkg::SETTLE_W_MAX-1:0] count
);

  logic [WIDTH-1:0] count_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (revEnd) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Unbuilt top bits read as zero.
  always_comb begin
    count = '0;
    count[WIDTH-1:0] = count_q;
  end

  assign firstRev = (count_q == '0);
  assign lastRev = (count_q == '1);

endmodule

//--- core/conv_register.sv
// Ten-bit converter register loaded bit by bit from the add-line comparison.
`timescale 1ns/100ps
module conv_register (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic load,
  input wire logic [3:0] bitIndex,
  input wire logic compare,
  // Data
  output logic [scan_seq_pkg::CONV_W-1:0] value
);

  logic [scan_seq_pkg::CONV_W-1:0] value_q;

  genvar i;
  generate
    for (i = 0; i < scan_seq_pkg::CONV_W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        // A bit loaded in the clearing cycle keeps its new value.
        if (rst) begin
          value_q[i] <= 1'b0;
        end else if (load && bitIndex == 4'(i)) begin
          value_q[i] <= compare;
        end else if (clear) begin
          value_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign value = value_q;

endmodule

//--- verification/scan_seq_properties.sv
// Concurrent checks on the scan sequencer's relay and revolution outputs.
`timescale 1ns/100ps
module scan_seq_properties #(
  parameter int SETTLE_W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched outputs
  input wire logic [31:0] relayGate,
  input wire logic relayReleaseGuard,
  input wire logic [scan_seq_pkg::SELECT_W-1:0] relaySelectCount,
  input wire logic firstRevolution,
  input wire logic lastRevolution
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [16:0] settleCycles_q;
  // Counts cycles since the first revolution ended.
  always_ff @(posedge clk) begin
    if (rst || firstRevolution) begin
      settleCycles_q <= 17'h0;
    end else begin
      settleCycles_q <= settleCycles_q + 17'h1;
    end
  end
  sequence s_guardRise;
    $rose(relayReleaseGuard);
  endsequence
  sequence s_newFirst;
    ##[0:2] firstRevolution;
  endsequence
  property p_gateDecode;
    relayGate == ($past(relayReleaseGuard) ? (32'h1 << $past(relaySelectCount)) : 32'h0);
  endproperty
  a_gateDecode: assert property (p_gateDecode) else $error("relay gate mismatch");
  property p_selStep;
    $changed(relaySelectCount) |-> relaySelectCount == $past(relaySelectCount) + 5'h1;
  endproperty
  a_selStep: assert property (p_selStep) else $error("select count bad step");
  property p_selCause;
    $changed(relaySelectCount) |-> s_guardRise;
  endproperty
  a_selCause: assert property (p_selCause) else $error("select count moved without guard");
  property p_guardSet;
    s_guardRise |-> firstRevolution;
  endproperty
  a_guardSet: assert property (p_guardSet) else $error("guard set outside first revolution");
  property p_guardClear;
    $fell(relayReleaseGuard) |-> s_newFirst;
  endproperty
  a_guardClear: assert property (p_guardClear) else $error("guard cleared off revolution end");
  property p_guardLow;
    $fell(relayReleaseGuard) |-> !relayReleaseGuard [*8];
  endproperty
  a_guardLow: assert property (p_guardLow) else $error("guard released early");
  property p_exclusive;
    !(firstRevolution && lastRevolution);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("first and last together");
  property p_lastToFirst;
    $fell(lastRevolution) |-> ##[0:1] firstRevolution;
  endproperty
  a_lastToFirst: assert property (p_lastToFirst) else $error("last not followed by first");
  property p_settle;
    $rose(lastRevolution) |-> settleCycles_q == 17'((2 ** SETTLE_W - 2) * 2560);
  endproperty
  a_settle: assert property (p_settle) else $error("settling length wrong");
endmodule
bind analog_input_scan_sequencer scan_seq_properties #(.SETTLE_W(SETTLE_W)) chk_u (
  .clk(clk),
  .rst(rst),
  .relayGate(relayGate),
  .relayReleaseGuard(relayReleaseGuard),
  .relaySelectCount(relaySelectCount),
  .firstRevolution(firstRevolution),
  .lastRevolution(lastRevolution)
);

//--- verification/drum_model.sv
// Storage drum timing: digit 1..20, sector 0..127, timing track bit.
`timescale 1ns/100ps
module drum_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Drum timing
  output logic [scan_seq_pkg::DIGIT_W-1:0] digitCount,
  output logic [scan_seq_pkg::SECTOR_W-1:0] sectorCount,
  output logic timingTrackBit
);
  always_ff @(posedge clk) begin
    if (rst) begin
      digitCount <= 5'h01;
      sectorCount <= 7'h00;
    end else if (digitCount == 5'h14) begin
      digitCount <= 5'h01;
      sectorCount <= sectorCount + 7'h01;
    end else begin
      digitCount <= digitCount + 5'h01;
    end
  end
  // The track reads zero at each revolution end and alternates elsewhere.
  assign timingTrackBit = (digitCount == 5'h14 && sectorCount == 7'h7F) ? 1'b0 : digitCount[0];
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the analog input scan sequencer.
`timescale 1ns/100ps
module tb_top;
  logic clk, rst, addLineDetector, convLoad, timingTrackBit;
  logic [4:0] digitCount;
  logic [6:0] sectorCount;
  logic [3:0] convBitIndex, wstrb;
  logic [31:0] relayGate, wdata, rdata;
  logic relayReleaseGuard, firstRevolution, lastRevolution;
  logic [4:0] relaySelectCount;
  logic [9:0] weightSwitch, convExp, e;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [33:0] expQ[$];
  int failures = 0;
  int samplesChecked = 0;
  integer seed;
  int n;
  logic [4:0] cnt;
  analog_input_scan_sequencer #(.SETTLE_W(2)) dut_u (.clk(clk), .rst(rst), .digitCount(digitCount),
    .sectorCount(sectorCount), .timingTrackBit(timingTrackBit), .addLineDetector(addLineDetector),
    .convLoad(convLoad), .convBitIndex(convBitIndex), .relayGate(relayGate),
    .relayReleaseGuard(relayReleaseGuard), .relaySelectCount(relaySelectCount), .weightSwitch(weightSwitch),
    .firstRevolution(firstRevolution), .lastRevolution(lastRevolution), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  drum_model drum_u (.clk(clk), .rst(rst), .digitCount(digitCount), .sectorCount(sectorCount),
    .timingTrackBit(timingTrackBit));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic stop_test;
    $display("failures %0d samplesChecked %0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] ex);
    samplesChecked++;
    if (seen !== ex) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic hang;
    failures++;
    stop_test();
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !(bvalid && !awvalid && !wvalid); n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk);
    if (n == 50) hang();
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expQ.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !(rvalid && !arvalid); n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
    if (n == 50) hang();
  endtask
  // Compares each bus answer with the oldest queued expectation.
  always @(posedge clk) begin
    if (bvalid && bready) check("bresp", {bresp, 32'h0}, expQ.pop_front());
    if (rvalid && rready) check("rdata", {rresp, rdata}, expQ.pop_front());
  end
  task automatic waitGuard(input logic lvl);
    for (n = 0; n < 12000 && relayReleaseGuard !== lvl; n++) @(posedge clk);
    if (n == 12000) hang();
    @(posedge clk);
  endtask
  initial begin
    seed = 32'h4AFBEA8B;
    rst = 1'b1;
    {addLineDetector, convLoad, convBitIndex, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    axiRead(8'h00, 32'h0, 2'h0);
    axiRead(8'h04, 32'h80, 2'h0);
    axiRead(8'h10, 32'h0, 2'h2);
    axiWrite(8'h14, 32'hF, 2'h2);
    axiWrite(8'h00, 32'h8, 2'h0);
    for (int i = 0; i < 11; i++) begin
      addLineDetector <= 1'($random(seed));
      repeat (3) @(posedge clk);
      convBitIndex <= 4'(i);
      convLoad <= 1'b1;
      if (i < 10) convExp[i] = addLineDetector;
      @(posedge clk);
      convLoad <= 1'b0;
    end
    axiRead(8'h08, {22'h0, convExp}, 2'h0);
    for (int m = 0; m < 4; m++) begin
      e = !m[0] ? 10'h0 : (m[1] ? 10'h3FF : convExp);
      axiWrite(8'h00, 32'(m), 2'h0);
      for (n = 0; n < 8 && weightSwitch !== e; n++) @(posedge clk);
      check("weightSwitch", {24'h0, weightSwitch}, {24'h0, e});
    end
    cnt = 5'h0;
    for (int s = 0; s < 3; s++) begin
      waitGuard(1'b1);
      cnt = cnt + 5'h1;
      check("relayGate", {2'h0, relayGate}, {2'h0, 32'h1 << cnt});
      axiRead(8'h04, {24'h0, 8'hA0 | 8'(cnt)}, 2'h0);
      waitGuard(1'b0);
      check("relayGate", {2'h0, relayGate}, 34'h0);
    end
    axiWrite(8'h0C, 32'(cnt), 2'h0);
    axiWrite(8'h00, 32'h4, 2'h0);
    waitGuard(1'b1);
    axiRead(8'h04, {24'h0, 8'hA0 | 8'(cnt)}, 2'h0);
    axiWrite(8'h00, 32'h0, 2'h0);
    stop_test();
  end
endmodule
